// >>> rtl/cdtu_card_detect.sv
// Purpose: border comparison and reporting of low power card detection
// Assumes: measurement strobes and samples come from the on-chip timing
//          engine on sys_clk; register master keeps strobes one cycle
// Notes:   NEWER_SILICON chooses whether the options register exists
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module cdtu_card_detect #(
  parameter bit NEWER_SILICON = 1'b1
) (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic [cdtu_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [cdtu_pkg::DATA_W-1:0] regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [cdtu_pkg::DATA_W-1:0] regRdData,
  input  wire logic                        measStart,
  input  wire logic                        measSample,
  input  wire logic [cdtu_pkg::VAL_W-1:0]  iSample,
  input  wire logic [cdtu_pkg::VAL_W-1:0]  qSample,
  input  wire logic                        measEnd,
  output logic                             txFullLevel,
  output logic                             noiseFilterEnable,
  output logic                             detectReq,
  output logic                             irq
);

  cdtu_pkg::cdtu_phase_t phase;               // measurement phase
  logic [cdtu_pkg::DATA_W-1:0] qLowerReg;     // q lower plus i upper 5:4
  logic [cdtu_pkg::DATA_W-1:0] qUpperReg;     // q upper plus i upper 3:2
  logic [cdtu_pkg::DATA_W-1:0] iLowerReg;     // i lower plus i upper 1:0
  logic [cdtu_pkg::VAL_W-1:0]  iResult;       // last i value
  logic [cdtu_pkg::VAL_W-1:0]  qResult;       // last q value
  logic                        detectIrqSuppress; // blocks requests
  logic                        qChannelUnstable;  // q changed in window
  logic                        iChannelUnstable;  // i changed in window
  logic [cdtu_pkg::VAL_W-1:0]  iUpperBorder;  // assembled i upper border
  logic [cdtu_pkg::VAL_W-1:0]  chanVal [2];   // filter outputs, i then q
  logic [1:0]                  chanUns;       // filter unstable flags
  logic [1:0]                  chanDone;      // filter finish pulses
  logic                        fStart;        // filter restart
  logic                        fSample;       // sample inside measurement
  logic                        fFinish;       // end inside measurement
  logic                        anyHit;        // some border crossed
  logic                        wrOpt;         // write decodes
  logic                        wrQRes;
  logic                        wrIrqEn;
  logic                        wrIrqClr;
  logic [cdtu_pkg::IRQ_W-1:0]  irqStatus;     // sticky status
  logic [cdtu_pkg::IRQ_W-1:0]  irqEnable;     // interrupt mask
  logic [cdtu_pkg::DATA_W-1:0] next_rdData;   // read mux
  logic                        cardDetectIrqFlag; // status bit view

  // the upper i border is scattered over three registers
  assign iUpperBorder = {
    qLowerReg[cdtu_pkg::SPLIT_MSB:cdtu_pkg::SPLIT_LSB],
    qUpperReg[cdtu_pkg::SPLIT_MSB:cdtu_pkg::SPLIT_LSB],
    iLowerReg[cdtu_pkg::SPLIT_MSB:cdtu_pkg::SPLIT_LSB]};

  // the old silicon has no options register, so decode it away
  assign wrOpt    = regWr && NEWER_SILICON &&
                    (regAddr == cdtu_pkg::ADDR_OPTIONS);
  assign wrQRes   = regWr && (regAddr == cdtu_pkg::ADDR_Q_RESULT);
  assign wrIrqEn  = regWr && (regAddr == cdtu_pkg::ADDR_IRQ_EN);
  assign wrIrqClr = regWr && (regAddr == cdtu_pkg::ADDR_IRQ_CLR);

  // sample and end strobes only count inside a measurement; start always restarts the filters
  assign fStart  = measStart;
  assign fSample = measSample && (phase == cdtu_pkg::PH_MEASURE);
  assign fFinish = measEnd && (phase == cdtu_pkg::PH_MEASURE);

  // phase tracking, a stray end outside a measurement is ignored
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      phase <= cdtu_pkg::PH_IDLE;
    else
    begin
      case (phase)
        cdtu_pkg::PH_IDLE:
          if (measStart)
            phase <= cdtu_pkg::PH_MEASURE;
        cdtu_pkg::PH_MEASURE:
          if (measEnd)
            phase <= cdtu_pkg::PH_IDLE;
        default:
          phase <= cdtu_pkg::PH_IDLE;
      endcase
    end
  end

  // one sampler per channel: index 0 is i, index 1 is q
  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_chan
      cdtu_chan_filter u_filter (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .start       (fStart),
        .sampleValid (fSample),
        .sample      ((c == 0) ? iSample : qSample),
        .finish      (fFinish),
        .filterOn    (noiseFilterEnable),
        .value       (chanVal[c]),
        .unstable    (chanUns[c]),
        .done        (chanDone[c])
      );
    end
  endgenerate

  // border crossings on the stable filter outputs
  assign anyHit =
    (chanVal[0] > iUpperBorder) ||
    (chanVal[1] > qUpperReg[cdtu_pkg::BORDER_MSB:cdtu_pkg::BORDER_LSB]) ||
    (chanVal[0] < iLowerReg[cdtu_pkg::BORDER_MSB:cdtu_pkg::BORDER_LSB]) ||
    (chanVal[1] < qLowerReg[cdtu_pkg::BORDER_MSB:cdtu_pkg::BORDER_LSB]);

  // border registers, whole bytes writable
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      qLowerReg <= cdtu_pkg::RST_BYTE;
      qUpperReg <= cdtu_pkg::RST_BYTE;
      iLowerReg <= cdtu_pkg::RST_BYTE;
    end
    else if (regWr)
    begin
      if (regAddr == cdtu_pkg::ADDR_Q_LOWER)
        qLowerReg <= regWrData;
      if (regAddr == cdtu_pkg::ADDR_Q_UPPER)
        qUpperReg <= regWrData;
      if (regAddr == cdtu_pkg::ADDR_I_LOWER)
        iLowerReg <= regWrData;
    end
  end

  // options: level and filter writable, flags follow each measurement
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      txFullLevel       <= 1'b0;
      noiseFilterEnable <= 1'b0;
    end
    else if (wrOpt)
    begin
      txFullLevel       <= regWrData[cdtu_pkg::OPT_TX_BIT];
      noiseFilterEnable <= regWrData[cdtu_pkg::OPT_FILT_BIT];
    end
  end

  // results and flags taken once per measurement, at filter finish
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      iResult          <= cdtu_pkg::RST_VAL;
      qResult          <= cdtu_pkg::RST_VAL;
      iChannelUnstable <= 1'b0;
      qChannelUnstable <= 1'b0;
    end
    else if (chanDone[0])
    begin
      iResult          <= chanVal[0];
      qResult          <= chanVal[1];
      iChannelUnstable <= chanUns[0];
      qChannelUnstable <= chanUns[1];
    end
  end

  // suppress bit: software set wins over the restart clear
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      detectIrqSuppress <= 1'b0;
    else if (wrQRes && regWrData[cdtu_pkg::SUPPRESS_BIT])
      detectIrqSuppress <= 1'b1;
    else if (measStart)
      detectIrqSuppress <= 1'b0;
    else if (wrQRes)
      detectIrqSuppress <= 1'b0;
  end

  // one request pulse per measurement, raised with the new results
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      detectReq <= 1'b0;
    else
      detectReq <= chanDone[0] && anyHit && !detectIrqSuppress;
  end

  // detection request feeds the sticky status flag
  cdtu_irq u_irq (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .eventIn (detectReq),
    .clrWr   (wrIrqClr),
    .clrData (regWrData[cdtu_pkg::IRQ_W-1:0]),
    .enWr    (wrIrqEn),
    .enData  (regWrData[cdtu_pkg::IRQ_W-1:0]),
    .status  (irqStatus),
    .enable  (irqEnable),
    .irq     (irq)
  );
  assign cardDetectIrqFlag = irqStatus[cdtu_pkg::IRQ_DET_BIT];

  // read mux, reserved bits and unmapped addresses give zero
  always_comb
  begin
    next_rdData = cdtu_pkg::RST_BYTE;
    case (regAddr)
      cdtu_pkg::ADDR_OPTIONS:
        if (NEWER_SILICON)
        begin
          next_rdData[cdtu_pkg::OPT_TX_BIT]   = txFullLevel;
          next_rdData[cdtu_pkg::OPT_FILT_BIT] = noiseFilterEnable;
          next_rdData[cdtu_pkg::OPT_QUNS_BIT] = qChannelUnstable;
          next_rdData[cdtu_pkg::OPT_IUNS_BIT] = iChannelUnstable;
        end
      cdtu_pkg::ADDR_Q_LOWER:  next_rdData = qLowerReg;
      cdtu_pkg::ADDR_Q_UPPER:  next_rdData = qUpperReg;
      cdtu_pkg::ADDR_I_LOWER:  next_rdData = iLowerReg;
      cdtu_pkg::ADDR_I_RESULT:
        next_rdData[cdtu_pkg::BORDER_MSB:cdtu_pkg::BORDER_LSB] =
          iResult;
      cdtu_pkg::ADDR_Q_RESULT:
      begin
        next_rdData[cdtu_pkg::BORDER_MSB:cdtu_pkg::BORDER_LSB] =
          qResult;
        next_rdData[cdtu_pkg::SUPPRESS_BIT] = detectIrqSuppress;
      end
      cdtu_pkg::ADDR_IRQ_STAT:
        next_rdData[cdtu_pkg::IRQ_DET_BIT] = cardDetectIrqFlag;
      cdtu_pkg::ADDR_IRQ_EN:
        next_rdData[cdtu_pkg::IRQ_W-1:0] = irqEnable;
      default:
        next_rdData = cdtu_pkg::RST_BYTE;
    endcase
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      regRdData <= cdtu_pkg::RST_BYTE;
    else if (regRd)
      regRdData <= next_rdData;
    else
      regRdData <= cdtu_pkg::RST_BYTE;
  end

  // checks on the visible behaviour
  chk_i_upper_hit: assert property (@(posedge sys_clk) disable iff (!nrst)
    (chanDone[0] && !detectIrqSuppress && (chanVal[0] > iUpperBorder))
      |=> detectReq)
    else $error("i above upper border raised no request");

  chk_q_upper_hit: assert property (@(posedge sys_clk) disable iff (!nrst)
    (chanDone[0] && !detectIrqSuppress &&
     (chanVal[1] > qUpperReg[cdtu_pkg::BORDER_MSB:cdtu_pkg::BORDER_LSB]))
      |=> detectReq)
    else $error("q above upper border raised no request");

  chk_i_lower_hit: assert property (@(posedge sys_clk) disable iff (!nrst)
    (chanDone[0] && !detectIrqSuppress &&
     (chanVal[0] < iLowerReg[cdtu_pkg::BORDER_MSB:cdtu_pkg::BORDER_LSB]))
      |=> detectReq)
    else $error("i below lower border raised no request");

  chk_q_lower_hit: assert property (@(posedge sys_clk) disable iff (!nrst)
    (chanDone[0] && !detectIrqSuppress &&
     (chanVal[1] < qLowerReg[cdtu_pkg::BORDER_MSB:cdtu_pkg::BORDER_LSB]))
      |=> detectReq)
    else $error("q below lower border raised no request");

  chk_no_false_req: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(chanDone[0] && anyHit) |=> !detectReq)
    else $error("request without a border crossing");

  chk_suppress_block: assert property (@(posedge sys_clk) disable iff (!nrst)
    detectIrqSuppress |=> !detectReq)
    else $error("request raised while suppressed");

  chk_result_take: assert property (@(posedge sys_clk) disable iff (!nrst)
    measEnd && (phase == cdtu_pkg::PH_MEASURE) |=> ##1
      (iResult == $past(chanVal[0])) && (qResult == $past(chanVal[1])))
    else $error("results not taken at measurement end");

  chk_i_res_resv: assert property (@(posedge sys_clk) disable iff (!nrst)
    regRd && (regAddr == cdtu_pkg::ADDR_I_RESULT) |=>
      regRdData[cdtu_pkg::SPLIT_MSB:cdtu_pkg::SPLIT_LSB] == 2'b00)
    else $error("reserved i result bits read nonzero");

  chk_q_res_resv: assert property (@(posedge sys_clk) disable iff (!nrst)
    regRd && (regAddr == cdtu_pkg::ADDR_Q_RESULT) |=>
      !regRdData[cdtu_pkg::SPLIT_MSB])
    else $error("reserved q result bit read nonzero");

  chk_tx_level_wr: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrOpt |=> txFullLevel == $past(regWrData[cdtu_pkg::OPT_TX_BIT]))
    else $error("tx level did not follow the options write");

  chk_unstable_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    fFinish && !noiseFilterEnable |=> ##1
      !iChannelUnstable && !qChannelUnstable)
    else $error("unstable flag set without the filter");

  chk_opt_resv: assert property (@(posedge sys_clk) disable iff (!nrst)
    regRd && (regAddr == cdtu_pkg::ADDR_OPTIONS) |=>
      (regRdData[cdtu_pkg::DATA_W-1:cdtu_pkg::OPT_TX_BIT+1] == '0) &&
      (NEWER_SILICON || (regRdData == cdtu_pkg::RST_BYTE)))
    else $error("options read shows reserved or missing bits");

  chk_req_to_irq: assert property (@(posedge sys_clk) disable iff (!nrst)
    detectReq ##1 irqEnable[cdtu_pkg::IRQ_DET_BIT] |-> ##1 irq)
    else $error("request did not reach the interrupt output");

  cov_detect_irq: cover property (@(posedge sys_clk) disable iff (!nrst)
    detectReq ##[1:3] irq);
  cov_suppressed: cover property (@(posedge sys_clk) disable iff (!nrst)
    detectIrqSuppress && chanDone[0] && anyHit);
  cov_unstable: cover property (@(posedge sys_clk) disable iff (!nrst)
    noiseFilterEnable && chanDone[0] && chanUns[1]);

endmodule // cdtu_card_detect

// >>> rtl/cdtu_chan_filter.sv
// Purpose: per-channel sampler and noise filter of one measurement
// Assumes: samples come from logic on sys_clk, no synchroniser needed
// Notes:   filtered value is the midpoint of the spread seen in the window
`timescale 1ns/1ps
module cdtu_chan_filter (
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire logic                      start,
  input  wire logic                      sampleValid,
  input  wire logic [cdtu_pkg::VAL_W-1:0] sample,
  input  wire logic                      finish,
  input  wire logic                      filterOn,
  output logic      [cdtu_pkg::VAL_W-1:0] value,
  output logic                           unstable,
  output logic                           done
);

  logic [cdtu_pkg::VAL_W-1:0] minV;     // smallest sample in window
  logic [cdtu_pkg::VAL_W-1:0] maxV;     // largest sample in window
  logic [cdtu_pkg::VAL_W-1:0] lastV;    // most recent sample
  logic [cdtu_pkg::WIN_W-1:0] winCount; // cycles since start, saturating
  logic                       inWin;    // filter may still sample
  logic [cdtu_pkg::VAL_W:0]   midSum;   // min plus max, one bit wider

  // samples beyond the window would lengthen rf-on time, so the filter drops them
  assign inWin  = (winCount < cdtu_pkg::SAMPLE_CYCLES);
  assign midSum = {1'b0, minV} + {1'b0, maxV};

  // window counter runs from start and stops at its bound
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      winCount <= cdtu_pkg::WIN_ZERO;
    else if (start)
      winCount <= cdtu_pkg::WIN_ZERO;
    else if (inWin)
      winCount <= winCount + cdtu_pkg::WIN_ONE;
  end

  // spread tracking in both modes; plain mode uses only the last sample
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || start)
    begin
      minV  <= cdtu_pkg::VAL_FULL;
      maxV  <= cdtu_pkg::RST_VAL;
      lastV <= cdtu_pkg::RST_VAL;
    end
    else if (sampleValid && (inWin || !filterOn))
    begin
      lastV <= sample;
      if (sample < minV)
        minV <= sample;
      if (sample > maxV)
        maxV <= sample;
    end
  end

  // result registered at finish; no sample seen gives the empty value
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      value    <= cdtu_pkg::RST_VAL;
      unstable <= 1'b0;
      done     <= 1'b0;
    end
    else
    begin
      done <= finish;
      if (finish)
      begin
        if (filterOn && (minV <= maxV))
          value <= midSum[cdtu_pkg::VAL_W:1];
        else
          value <= lastV;
        unstable <= filterOn && (minV < maxV);
      end
    end
  end

  chk_win_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
    winCount <= cdtu_pkg::SAMPLE_CYCLES)
    else $error("sample window counter ran past its bound");

endmodule // cdtu_chan_filter

// >>> rtl/cdtu_irq.sv
// Purpose: sticky interrupt status with enable and write-one clear
// Assumes: event pulses and register strobes on sys_clk
// Notes:   a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
module cdtu_irq (
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire logic [cdtu_pkg::IRQ_W-1:0] eventIn,
  input  wire logic                      clrWr,
  input  wire logic [cdtu_pkg::IRQ_W-1:0] clrData,
  input  wire logic                      enWr,
  input  wire logic [cdtu_pkg::IRQ_W-1:0] enData,
  output logic      [cdtu_pkg::IRQ_W-1:0] status,
  output logic      [cdtu_pkg::IRQ_W-1:0] enable,
  output logic                           irq
);

  // sticky status per event bit, set beats clear
  genvar b;
  generate
    for (b = 0; b < cdtu_pkg::IRQ_W; b++)
    begin : g_bit
      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
          status[b] <= 1'b0;
        else if (eventIn[b])
          status[b] <= 1'b1;
        else if (clrWr && clrData[b])
          status[b] <= 1'b0;
      end
    end
  endgenerate

  // enable mask written as a whole
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      enable <= '0;
    else if (enWr)
      enable <= enData;
  end

  // registered level, one cycle behind status
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(status & enable);
  end

  chk_set_wins: assert property (@(posedge sys_clk) disable iff (!nrst)
    (eventIn[cdtu_pkg::IRQ_DET_BIT] && clrWr) |=>
      status[cdtu_pkg::IRQ_DET_BIT])
    else $error("event lost against a clear");

  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!nrst)
    (status & enable) != '0 |=> irq)
    else $error("enabled status did not raise the interrupt");

endmodule // cdtu_irq

// >>> rtl/cdtu_pkg.sv
// Purpose: shared constants of the card detect threshold unit
// Assumes: 8-bit register port, 100 MHz sys_clk
// Notes:   every offset, field position and count of the block lives here, bar the channel count of two
//
// Notes on behaviour
// - i upper bits 3:2 in q upper 7:6
// - i upper bits 1:0 in i lower 7:6
// - q above q upper raises request
// - i below i lower raises request
// - i result read-only, bits 7:6 zero
// - q result writable only in suppress bit 6, bit 7 zero
// - suppress bit blocks requests until next start
// - tx level bit picks full or reduced supply
// - filter bit selects filtered decision, 4.72us window
// - q unstable flag, meaningful with filter only
// - i unstable flag, meaningful with filter only
// - options register only on newer silicon
// - i upper bits 5:4 in q lower 7:6
// - q lower border, request via status flag
package cdtu_pkg;

  // data and address widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int VAL_W  = 6;

  // register offsets, printed ones first
  localparam logic [ADDR_W-1:0] ADDR_OPTIONS  = 8'h3a;
  localparam logic [ADDR_W-1:0] ADDR_Q_LOWER  = 8'h3f;
  localparam logic [ADDR_W-1:0] ADDR_Q_UPPER  = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_I_LOWER  = 8'h41;
  localparam logic [ADDR_W-1:0] ADDR_I_RESULT = 8'h42;
  localparam logic [ADDR_W-1:0] ADDR_Q_RESULT = 8'h43;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h50;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 8'h51;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 8'h52;

  // field positions
  localparam int BORDER_LSB   = 0;
  localparam int BORDER_MSB   = 5;
  localparam int SPLIT_LSB    = 6;
  localparam int SPLIT_MSB    = 7;
  localparam int SUPPRESS_BIT = 6;
  localparam int OPT_TX_BIT   = 3;
  localparam int OPT_FILT_BIT = 2;
  localparam int OPT_QUNS_BIT = 1;
  localparam int OPT_IUNS_BIT = 0;
  localparam int IRQ_W        = 1;
  localparam int IRQ_DET_BIT  = 0;

  // reset values
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [VAL_W-1:0]  RST_VAL  = 6'h00;
  localparam logic [VAL_W-1:0]  VAL_FULL = 6'h3f;

  // reduced transmitter level is supply minus this drop
  localparam int TX_DROP_MV = 400;

  // filtered sampling window, longest time so rounded down
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SAMPLE_TIME_NS = 4720;
  localparam int WIN_W          = 9;
  localparam logic [WIN_W-1:0] SAMPLE_CYCLES =
    WIN_W'(SAMPLE_TIME_NS / CLK_PERIOD_NS);
  localparam logic [WIN_W-1:0] WIN_ZERO = 9'h000;
  localparam logic [WIN_W-1:0] WIN_ONE  = 9'h001;

  // phases of one detection measurement
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_MEASURE
  } cdtu_phase_t;

endpackage // cdtu_pkg

// >>> testbench/card_detect_threshold_unit_tb_top.sv
// Purpose: self-checking bench of the card detect threshold unit
// Assumes: read data stand only in the cycle after the read strobe
// Notes:   the bench plays the timing engine on the sample ports
`timescale 1ns/1ps
module card_detect_threshold_unit_tb_top;
  logic       sys_clk = 1'b0;     // 100 MHz
  logic       nrst = 1'b0;        // sync, active low
  logic [7:0] regAddr = 8'h00;    // register byte address
  logic [7:0] regWrData = 8'h00;  // write data
  logic       regWr = 1'b0;       // write strobe
  logic       regRd = 1'b0;       // read strobe
  logic [7:0] regRdData;          // read data
  logic       measStart = 1'b0;   // detection begins
  logic       measSample = 1'b0;  // sample strobe
  logic [5:0] iSample = 6'h00;    // i channel sample
  logic [5:0] qSample = 6'h00;    // q channel sample
  logic       measEnd = 1'b0;     // detection ends
  logic       txFullLevel;        // tx level select
  logic       noiseFilterEnable;  // filter select
  logic       detectReq;          // request pulse
  logic       irq;                // level interrupt
  int         mismatches = 0;     // failed compares
  int         total_checks = 0;   // all compares
  int         cycles = 0;         // hang guard
  logic       seen;               // request seen in window
  logic [7:0] regRdDataOld;       // read data, old silicon copy
  logic       txFullLevelOld;     // tx level, old silicon copy
  logic       noiseFilterEnableOld; // filter, old silicon copy

  cdtu_card_detect #(.NEWER_SILICON(1'b1)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .measStart(measStart),
    .measSample(measSample), .iSample(iSample), .qSample(qSample),
    .measEnd(measEnd), .txFullLevel(txFullLevel),
    .noiseFilterEnable(noiseFilterEnable), .detectReq(detectReq),
    .irq(irq));

  // old silicon copy on the same bus: options place must stay dead
  cdtu_card_detect #(.NEWER_SILICON(1'b0)) dutOld (
    .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdDataOld), .measStart(measStart),
    .measSample(measSample), .iSample(iSample), .qSample(qSample),
    .measEnd(measEnd), .txFullLevel(txFullLevelOld),
    .noiseFilterEnable(noiseFilterEnableOld), .detectReq(),
    .irq());

  // free running clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // verdict in one place
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // byte compare, also used for single flags
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // one-cycle write strobe, then a quiet cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // one-cycle read strobe; data taken in the next cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(e, regRdData);
  endtask

  // one measurement of two samples; sup writes suppress mid-way
  task automatic meas(input logic [5:0] i0, q0, i1, q1, input bit sup);
    @(posedge sys_clk);
    measStart <= 1'b1;
    @(posedge sys_clk);
    measStart <= 1'b0;
    if (sup) wr(8'h43, 8'h40);
    measSample <= 1'b1;
    iSample <= i0;
    qSample <= q0;
    @(posedge sys_clk);
    iSample <= i1;
    qSample <= q1;
    @(posedge sys_clk);
    measSample <= 1'b0;
    measEnd <= 1'b1;
    @(posedge sys_clk);
    measEnd <= 1'b0;
    seen = 1'b0;
    repeat (6) @(posedge sys_clk) #1 if (detectReq === 1'b1) seen = 1'b1;
  endtask

  // reset values of every register and an unmapped place
  task automatic test_reset();
    logic [7:0] al [9] = '{8'h3a, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43,
                           8'h50, 8'h51, 8'h77};
    foreach (al[k]) rd(al[k], 8'h00);
    chk(8'h00, {6'h00, txFullLevel, noiseFilterEnable});
    $display("test reset done");
  endtask

  // border split fields, read-only result, options access
  task automatic test_regs();
    wr(8'h3f, 8'h85);
    wr(8'h40, 8'h70);
    wr(8'h41, 8'hc8);
    rd(8'h3f, 8'h85);
    rd(8'h40, 8'h70);
    rd(8'h41, 8'hc8);
    wr(8'h42, 8'hff);
    rd(8'h42, 8'h00);
    wr(8'h77, 8'hff);
    rd(8'h77, 8'h00);
    wr(8'h3a, 8'hff);
    rd(8'h3a, 8'h0c);
    chk(8'h00, regRdDataOld);
    chk(8'h03, {6'h00, txFullLevel, noiseFilterEnable});
    chk(8'h00, {6'h00, txFullLevelOld, noiseFilterEnableOld});
    wr(8'h3a, 8'h00);
    #1 chk(8'h00, {7'h00, txFullLevel});
    $display("test regs done");
  endtask

  // i upper 0x27, q upper 0x30, i lower 0x08, q lower 0x05
  task automatic test_borders();
    logic [12:0] tc [9] = '{{6'h10, 6'h10, 1'b0}, {6'h27, 6'h10, 1'b0},
      {6'h28, 6'h10, 1'b1}, {6'h08, 6'h10, 1'b0}, {6'h07, 6'h10, 1'b1},
      {6'h10, 6'h30, 1'b0}, {6'h10, 6'h31, 1'b1}, {6'h10, 6'h05, 1'b0},
      {6'h10, 6'h04, 1'b1}};
    foreach (tc[k])
    begin
      meas(tc[k][12:7], tc[k][6:1], tc[k][12:7], tc[k][6:1], 1'b0);
      chk({7'h00, tc[k][0]}, {7'h00, seen});
      rd(8'h42, {2'b00, tc[k][12:7]});
      rd(8'h43, {2'b00, tc[k][6:1]});
    end
    $display("test borders done");
  endtask

  // enabled event drives irq, clear drops it, masked event stays quiet
  task automatic test_irq();
    wr(8'h52, 8'h01);
    wr(8'h51, 8'h01);
    meas(6'h28, 6'h10, 6'h28, 6'h10, 1'b0);
    chk(8'h01, {7'h00, irq});
    rd(8'h50, 8'h01);
    wr(8'h52, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 chk(8'h00, {7'h00, irq});
    wr(8'h51, 8'h00);
    meas(6'h10, 6'h04, 6'h10, 6'h04, 1'b0);
    rd(8'h50, 8'h01);
    chk(8'h00, {7'h00, irq});
    wr(8'h52, 8'h01);
    rd(8'h50, 8'h00);
    $display("test irq done");
  endtask

  // suppress set inside a measurement, released by the next start
  task automatic test_suppress();
    meas(6'h28, 6'h10, 6'h28, 6'h10, 1'b1);
    chk(8'h00, {7'h00, seen});
    rd(8'h43, 8'h50);
    meas(6'h28, 6'h10, 6'h28, 6'h10, 1'b0);
    chk(8'h01, {7'h00, seen});
    rd(8'h43, 8'h10);
    $display("test suppress done");
  endtask

  // last sample without filter, midpoint and unstable flags with it
  task automatic test_filter();
    meas(6'h10, 6'h20, 6'h14, 6'h20, 1'b0);
    rd(8'h42, 8'h14);
    wr(8'h3a, 8'h04);
    meas(6'h10, 6'h20, 6'h14, 6'h20, 1'b0);
    rd(8'h42, 8'h12);
    rd(8'h3a, 8'h05);
    meas(6'h10, 6'h20, 6'h10, 6'h24, 1'b0);
    rd(8'h43, 8'h22);
    rd(8'h3a, 8'h06);
    $display("test filter done");
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    test_reset();
    test_regs();
    test_borders();
    test_irq();
    test_suppress();
    test_filter();
    end_sim();
  end
endmodule // card_detect_threshold_unit_tb_top
